// [verilog/scd_pkg.sv]
// Shared constants and types of the system clock divider and sleep gating.
// Assumes a single master clock and an APB register slave with 32-bit data.
package scd_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_PRESCALE   = 8'h61;
  localparam logic [7:0] IDX_SLEEP_CTRL = 8'h62;
  localparam logic [7:0] IDX_STATUS     = 8'h63;
  localparam int         ADDR_W         = 12;

  // Field positions of the prescale control register.
  localparam int UNLOCK_BIT  = 7;
  localparam int SEL_LSB     = 0;
  localparam int SEL_W       = 4;
  // Unlock key: bit 7 set, every other bit clear.
  localparam logic [7:0] UNLOCK_KEY = 8'h80;

  // Field positions of the sleep mode control register.
  localparam int SLEEP_EN_BIT = 0;
  localparam int MODE_LSB     = 1;
  localparam int MODE_W       = 3;

  // Reset values of the select field.
  localparam logic [3:0] SEL_RST_DIV1 = 4'h0;
  localparam logic [3:0] SEL_RST_DIV8 = 4'h3;
  // Highest legal select code (divide by 256).
  localparam logic [3:0] SEL_MAX      = 4'h8;

  // Unlock window length in master clock cycles.
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // Core halt after wake-up, added to the start-up time.
  localparam logic [4:0] WAKE_HALT_CYCLES = 5'h04;
  // Start-up time of the oscillator after standby, in clock cycles.
  localparam logic [4:0] STANDBY_START_CYCLES = 5'h06;
  // Start-up time after power-down and power-save, in clock cycles.
  localparam logic [4:0] DEEP_START_CYCLES = 5'h06;

  // Sleep mode encodings.
  localparam logic [2:0] MODE_IDLE      = 3'h0;
  localparam logic [2:0] MODE_CONV_NR   = 3'h1;
  localparam logic [2:0] MODE_PWR_DOWN  = 3'h2;
  localparam logic [2:0] MODE_PWR_SAVE  = 3'h3;
  localparam logic [2:0] MODE_STANDBY   = 3'h6;

  // Sleep controller states.
  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } scd_state_e;

  // Per-domain clock gate enables.
  typedef struct packed {
    logic core;
    logic progmem;
    logic periph_io;
    logic converter;
  } scd_gate_s;

  // Wake-up sources presented by the rest of the chip.
  typedef struct packed {
    logic irq_any;
    logic ext_irq0;
    logic ext_irq0_level;
    logic pin_change;
    logic serial_start;
    logic timer_two;
    logic display;
    logic converter;
    logic nvm_ready;
  } scd_wake_s;

endpackage : scd_pkg

// [verilog/scd_clock_sleep.sv]
// System clock divider with protected change sequence and sleep gating.
// Assumes APB in the master clock domain and wake sources synchronous to it.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps

module scd_clock_sleep (
  // Clock and reset.
  input  wire logic                         i_core_clk,
  input  wire logic                         i_sys_rst,
  // Straps sampled while reset is high.
  input  wire logic                         i_div8_fuse_prog,
  input  wire logic                         i_crystal_sel,
  // APB slave.
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [scd_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Core and peripheral status.
  input  wire logic                         i_sleep_instr,
  input  wire logic                         i_conv_enabled,
  input  wire logic                         i_async_used,
  input  wire scd_pkg::scd_wake_s           i_wake,
  // Divided clock domain enables, one pulse per divided period.
  output scd_pkg::scd_gate_s                o_clk_en,
  // Oscillator controls and sleep status.
  output logic                              o_async_osc_run,
  output logic                              o_main_osc_run,
  output logic                              o_timer_two_run,
  output logic                              o_conv_start,
  output logic                              o_core_halt,
  output logic                              o_wake_irq
);

  // Register state.
  logic [3:0]              sel_q, sel_d;        // Active select code.
  logic [3:0]              pend_sel_q, pend_sel_d; // Select waiting to apply.
  logic                    pend_q, pend_d;      // A select change waits.
  logic                    unlock_q, unlock_d;  // Change-unlock flag.
  logic [2:0]              ucnt_q, ucnt_d;      // Unlock window counter.
  logic [7:0]              dcnt_q, dcnt_d;      // Divider count.
  logic                    se_q, se_d;          // Sleep enable bit.
  logic [2:0]              mode_q, mode_d;      // Sleep mode select.
  logic [2:0]              amode_q, amode_d;    // Mode actually entered.
  scd_pkg::scd_state_e     st_q, st_d;          // Sleep controller state.
  logic [4:0]              wcnt_q, wcnt_d;      // Wake halt counter.
  logic                    tick_q;              // Registered divided tick.
  scd_pkg::scd_gate_s      gate_q, gate_d;      // Domain gates.
  logic                    cstart_q;            // Conversion start pulse.
  logic                    wirq_q;              // Wake irq pulse.
  logic                    xtal_q;              // Captured crystal strap.
  logic [31:0]             rdata_q;             // Read data.
  logic                    err_q;               // Error response.

  // Bus decode wires.
  localparam int ADDR_HI = scd_pkg::ADDR_W - 1;
  wire logic [7:0] idx      = paddr[9:2];
  wire logic       acc      = psel & penable;
  wire logic       mapped   = (paddr[ADDR_HI:10] == '0) &&
                              (paddr[1:0] == 2'h0) &&
                              ((idx == scd_pkg::IDX_PRESCALE) ||
                               (idx == scd_pkg::IDX_SLEEP_CTRL) ||
                               (idx == scd_pkg::IDX_STATUS));
  wire logic       wr_acc   = acc & pwrite & mapped;
  wire logic       wr_pre   = wr_acc & (idx == scd_pkg::IDX_PRESCALE);
  wire logic       wr_slp   = wr_acc & (idx == scd_pkg::IDX_SLEEP_CTRL);
  wire logic [3:0] w_sel    = pwdata[scd_pkg::SEL_LSB +: scd_pkg::SEL_W];
  wire logic       key_wr   = wr_pre &
                              (pwdata[7:0] == scd_pkg::UNLOCK_KEY);
  wire logic       sel_wr   = wr_pre & unlock_q &
                              ~pwdata[scd_pkg::UNLOCK_BIT];
  wire logic       sel_ok   = (w_sel <= scd_pkg::SEL_MAX);

  // Divider mask: all ones below the select code.
  // divide by two to the code
  wire logic [8:0] mask9    = (9'h001 << sel_q) - 9'h001;
  wire logic [7:0] mask     = mask9[7:0];
  wire logic       tick     = ((dcnt_q & mask) == mask);

  // Wake decode by the mode that was entered.
  wire logic deep_irq0 = i_wake.ext_irq0 & i_wake.ext_irq0_level;
  wire logic wake_base = deep_irq0 | i_wake.pin_change |
                         i_wake.serial_start;
  logic       wake_req;
  logic [4:0] start_cyc;

  // Wake source selection and start-up time per sleep mode.
  always_comb begin
    wake_req  = 1'b0;
    start_cyc = 5'h00;
    unique case (amode_q)
      scd_pkg::MODE_IDLE: begin
        wake_req = i_wake.irq_any | i_wake.ext_irq0 | wake_base;
      end
      scd_pkg::MODE_CONV_NR: begin
        wake_req = wake_base | i_wake.converter | i_wake.nvm_ready |
                   i_wake.timer_two | i_wake.display;
      end
      // timer two and display wake power-save
      scd_pkg::MODE_PWR_SAVE: begin
        wake_req  = wake_base | i_wake.timer_two | i_wake.display;
        start_cyc = scd_pkg::DEEP_START_CYCLES;
      end
      scd_pkg::MODE_STANDBY: begin
        wake_req  = wake_base;
        start_cyc = scd_pkg::STANDBY_START_CYCLES;
      end
      // deeper modes wake only on level irq zero, pin change or serial start
      default: begin
        wake_req  = wake_base;
        start_cyc = scd_pkg::DEEP_START_CYCLES;
      end
    endcase
  end

  // Unlock window and select sequencing.
  always_comb begin
    unlock_d   = unlock_q;
    ucnt_d     = ucnt_q;
    pend_d     = pend_q;
    pend_sel_d = pend_sel_q;
    sel_d      = sel_q;
    if (unlock_q) begin
      ucnt_d = ucnt_q - 3'h1;
      if (ucnt_q == 3'h1) begin
        unlock_d = 1'b0;
      end
    end
    if (sel_wr) begin
      unlock_d = 1'b0;
      ucnt_d   = 3'h0;
      // any legal code regardless of fuse
      if (sel_ok) begin
        pend_d     = 1'b1;
        pend_sel_d = w_sel;
      end
    end else if (key_wr && !unlock_q) begin
      unlock_d = 1'b1;
      ucnt_d   = scd_pkg::UNLOCK_CYCLES;
    end
    // key write during window is ignored
    // switch only at the end of an old period
    // new period starts from zero after the switch
    if (pend_q && tick) begin
      sel_d  = pend_sel_q;
      pend_d = sel_wr & sel_ok;
    end
  end

  // divider counts on every master edge
  assign dcnt_d = (pend_q && tick) ? 8'h00 : dcnt_q + 8'h01;

  // Sleep controller: entry, halt and wake timing.
  always_comb begin
    st_d    = st_q;
    wcnt_d  = wcnt_q;
    amode_d = amode_q;
    unique case (st_q)
      scd_pkg::ST_RUN: begin
        // sleep needs enable bit and instruction
        if (i_sleep_instr && se_q) begin
          st_d    = scd_pkg::ST_SLEEP;
          amode_d = mode_q;
          // standby without crystal acts as power-down
          if (mode_q == scd_pkg::MODE_STANDBY && !xtal_q) begin
            amode_d = scd_pkg::MODE_PWR_DOWN;
          end
        end
      end
      scd_pkg::ST_SLEEP: begin
        if (wake_req) begin
          st_d   = scd_pkg::ST_WAKE;
          wcnt_d = scd_pkg::WAKE_HALT_CYCLES + start_cyc;
        end
      end
      scd_pkg::ST_WAKE: begin
        wcnt_d = wcnt_q - 5'h01;
        if (wcnt_q == 5'h01) begin
          st_d = scd_pkg::ST_RUN;
        end
      end
    endcase
  end

  // Domain gates per entered mode.
  always_comb begin
    gate_d = '{core: 1'b1, progmem: 1'b1, periph_io: 1'b1,
               converter: 1'b1};
    if (st_q != scd_pkg::ST_RUN) begin
      gate_d.core    = 1'b0;
      gate_d.progmem = 1'b0;
      // Idle keeps I/O and converter clocks
      // noise reduction also stops I/O clock
      // deeper modes stop every generated clock
      if (amode_q != scd_pkg::MODE_IDLE) begin
        gate_d.periph_io = 1'b0;
      end
      if (amode_q != scd_pkg::MODE_IDLE &&
          amode_q != scd_pkg::MODE_CONV_NR) begin
        gate_d.converter = 1'b0;
      end
    end
  end

  // Main clock and async oscillator control.
  wire logic asleep   = (st_q == scd_pkg::ST_SLEEP);
  wire logic shallow  = (amode_q == scd_pkg::MODE_IDLE) ||
                        (amode_q == scd_pkg::MODE_CONV_NR);
  // power-down and power-save stop the oscillator
  assign o_main_osc_run  = ~asleep | shallow |
                           (amode_q == scd_pkg::MODE_STANDBY);
  // async oscillator only when async clocking used
  assign o_async_osc_run = i_async_used &
                           (~asleep | shallow |
                            (amode_q == scd_pkg::MODE_PWR_SAVE));
  // timer two and display keep running in power-save
  assign o_timer_two_run = ~asleep | shallow |
                           (amode_q == scd_pkg::MODE_PWR_SAVE);
  assign o_core_halt     = (st_q != scd_pkg::ST_RUN);
  // no state here touches register file or RAM

  // Read data multiplexer.
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (idx == scd_pkg::IDX_PRESCALE) begin
      // select reads as written; the count stays hidden
      rmux[scd_pkg::UNLOCK_BIT] = unlock_q;
      rmux[scd_pkg::SEL_LSB +: scd_pkg::SEL_W] = pend_q ? pend_sel_q : sel_q;
    end else if (idx == scd_pkg::IDX_SLEEP_CTRL) begin
      rmux[scd_pkg::SLEEP_EN_BIT] = se_q;
      rmux[scd_pkg::MODE_LSB +: scd_pkg::MODE_W] = mode_q;
    end else if (idx == scd_pkg::IDX_STATUS) begin
      rmux[0]   = asleep;
      rmux[1]   = o_core_halt;
      rmux[2]   = pend_q;
      rmux[5:3] = amode_q;
    end
  end

  // Sleep control register next value.
  assign se_d   = wr_slp ? pwdata[scd_pkg::SLEEP_EN_BIT] : se_q;
  assign mode_d = wr_slp ? pwdata[scd_pkg::MODE_LSB +: scd_pkg::MODE_W]
                         : mode_q;

  // Divider, unlock and select registers.
  // reset select follows the fuse
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sel_q      <= i_div8_fuse_prog ? scd_pkg::SEL_RST_DIV8
                                     : scd_pkg::SEL_RST_DIV1;
      pend_sel_q <= 4'h0;
      pend_q     <= 1'b0;
      unlock_q   <= 1'b0;
      ucnt_q     <= 3'h0;
      dcnt_q     <= 8'h00;
      xtal_q     <= i_crystal_sel;
    end else begin
      sel_q      <= sel_d;
      pend_sel_q <= pend_sel_d;
      pend_q     <= pend_d;
      unlock_q   <= unlock_d;
      ucnt_q     <= ucnt_d;
      dcnt_q     <= dcnt_d;
      xtal_q     <= xtal_q;
    end
  end

  // Sleep controller registers.
  // reset drops sleep and restarts the core
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_q    <= scd_pkg::ST_RUN;
      wcnt_q  <= 5'h00;
      amode_q <= scd_pkg::MODE_IDLE;
      se_q    <= 1'b0;
      mode_q  <= scd_pkg::MODE_IDLE;
    end else begin
      st_q    <= st_d;
      wcnt_q  <= wcnt_d;
      amode_q <= amode_d;
      se_q    <= se_d;
      mode_q  <= mode_d;
    end
  end

  // Gates, pulses and bus answer registers.
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      tick_q   <= 1'b0;
      gate_q   <= '0;
      cstart_q <= 1'b0;
      wirq_q   <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else begin
      tick_q <= tick;
      // gates change only on a divided tick
      if (tick) begin
        gate_q <= gate_d;
      end
      cstart_q <= (st_q == scd_pkg::ST_RUN) && (st_d == scd_pkg::ST_SLEEP) &&
                  (amode_d == scd_pkg::MODE_IDLE) && i_conv_enabled;
      wirq_q   <= (st_q == scd_pkg::ST_WAKE) && (st_d == scd_pkg::ST_RUN);
      rdata_q  <= (psel && !penable && !pwrite && mapped) ? rmux
                                                           : rdata_q;
      err_q    <= psel & ~penable & ~mapped;
    end
  end

  // divided tick drives every domain through its gate
  assign o_clk_en.core      = tick_q & gate_q.core;
  assign o_clk_en.progmem   = tick_q & gate_q.progmem;
  assign o_clk_en.periph_io = tick_q & gate_q.periph_io;
  assign o_clk_en.converter = tick_q & gate_q.converter;
  assign o_conv_start       = cstart_q;
  assign o_wake_irq         = wirq_q;

  // APB answer: one wait-free access phase.
  assign pready  = 1'b1;
  assign pslverr = acc & err_q;
  assign prdata  = rdata_q;

endmodule : scd_clock_sleep

// [verif/scd_clock_sleep_assertions.sv]
// Port checker for the clock divider and sleep gating block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps

module scd_clock_sleep_assertions (
  // Clock and reset.
  input wire logic               i_core_clk,
  input wire logic               i_sys_rst,
  // Observed inputs.
  input wire logic               i_sleep_instr,
  input wire logic               i_conv_enabled,
  // Observed outputs.
  input wire scd_pkg::scd_gate_s o_clk_en,
  input wire logic               o_core_halt,
  input wire logic               o_conv_start,
  input wire logic               o_wake_irq,
  input wire logic               o_main_osc_run
);
  // All checks share the master clock and its reset.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // Entry into and exit from the halted state.
  sequence s_entry; $rose(o_core_halt); endsequence
  sequence s_leave; $fell(o_core_halt); endsequence
  // The wake pulse lasts exactly one cycle.
  sequence s_irq; o_wake_irq ##1 !o_wake_irq; endsequence

  property p_halt_cause; s_entry |-> $past(i_sleep_instr); endproperty
  a_halt_cause: assert property (p_halt_cause)
    else $error("Halt rose without a sleep instruction.");

  property p_halt_min; s_entry |-> o_core_halt [*4]; endproperty
  a_halt_min: assert property (p_halt_min)
    else $error("Halt lasted fewer than four cycles.");

  property p_wake_irq; s_leave |-> ##[0:1] s_irq; endproperty
  a_wake_irq: assert property (p_wake_irq)
    else $error("No single wake pulse after the halt ended.");

  property p_core_gated;
    o_core_halt [*3] |-> !o_clk_en.core && !o_clk_en.progmem;
  endproperty
  a_core_gated: assert property (p_core_gated)
    else $error("Core or program clock pulsed while halted.");

  property p_domains;
    o_clk_en.core |-> o_clk_en.progmem && o_clk_en.periph_io
      && o_clk_en.converter;
  endproperty
  a_domains: assert property (p_domains)
    else $error("Running domains are not pulsed together.");

  property p_conv_start;
    o_conv_start |-> o_core_halt && $past(i_conv_enabled);
  endproperty
  a_conv_start: assert property (p_conv_start)
    else $error("Conversion start outside a sleep entry.");

  property p_osc_stop; !o_main_osc_run |-> o_core_halt; endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("Main oscillator stopped while running.");

  property p_rst_wake;
    $fell(i_sys_rst) |-> !o_core_halt && (o_clk_en == 4'h0);
  endproperty
  a_rst_wake: assert property (p_rst_wake)
    else $error("Block still halted after reset.");
endmodule : scd_clock_sleep_assertions

bind scd_clock_sleep scd_clock_sleep_assertions i_sva (
  .i_core_clk, .i_sys_rst, .i_sleep_instr, .i_conv_enabled,
  .o_clk_en, .o_core_halt, .o_conv_start, .o_wake_irq, .o_main_osc_run);

// [verif/scd_clock_sleep_tb_top.sv]
// Self-checking bench for the clock divider and sleep gating block.
// Drives APB, sleep and wake inputs; no partner model is needed.
`timescale 1ns/1ps

module scd_clock_sleep_tb_top;
  // Prescale table row and sleep mode table row.
  typedef struct {logic [3:0] sel; int per;} scd_prow_s;
  typedef struct packed {logic [2:0] code; logic io, cv, osc;} scd_mrow_s;
  localparam logic [11:0] A_PRE = {2'h0, scd_pkg::IDX_PRESCALE, 2'h0};
  localparam logic [11:0] A_SLP = {2'h0, scd_pkg::IDX_SLEEP_CTRL, 2'h0};
  localparam logic [11:0] A_BAD = 12'h3fc;
  logic        i_core_clk, i_sys_rst, i_div8_fuse_prog, i_crystal_sel;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        i_sleep_instr, i_conv_enabled, i_async_used;
  logic        o_async_osc_run, o_main_osc_run, o_timer_two_run;
  logic        o_conv_start, o_core_halt, o_wake_irq;
  scd_pkg::scd_wake_s i_wake;
  scd_pkg::scd_gate_s o_clk_en;
  int          err_total = 0, cmp_count = 0;
  int          n_io = 0, n_cv = 0, n_cs = 0;
  scd_prow_s   prows [9] = '{'{4'h1, 2}, '{4'h8, 256}, '{4'h5, 32},
    '{4'h3, 8}, '{4'h2, 4}, '{4'h4, 16}, '{4'h6, 64}, '{4'h7, 128},
    '{4'h0, 1}};
  scd_mrow_s   mrows [5] = '{'{3'h0, 1'b1, 1'b1, 1'b1},
    '{3'h1, 1'b0, 1'b1, 1'b1}, '{3'h2, 1'b0, 1'b0, 1'b0},
    '{3'h3, 1'b0, 1'b0, 1'b0}, '{3'h6, 1'b0, 1'b0, 1'b1}};

  scd_clock_sleep i_dut (.i_core_clk, .i_sys_rst, .i_div8_fuse_prog,
    .i_crystal_sel, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .i_sleep_instr, .i_conv_enabled, .i_async_used,
    .i_wake, .o_clk_en, .o_async_osc_run, .o_main_osc_run,
    .o_timer_two_run, .o_conv_start, .o_core_halt, .o_wake_irq);

  // Master clock, 8 ns period.
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end

  // Counts pulses of the peripheral and converter domains.
  always @(posedge i_core_clk) begin
    if (o_clk_en.periph_io === 1'b1) n_io <= n_io + 1;
    if (o_clk_en.converter === 1'b1) n_cv <= n_cv + 1;
    if (o_conv_start === 1'b1) n_cs <= n_cs + 1;
  end

  // Prints the counts and the verdict, then ends the run.
  task print_verdict;
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // Compares one value and reports a mismatch.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_core_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      print_verdict();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // Reads a register and compares its value.
  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk

  // Unlock write, optional idle gap, then the select write.
  task key_sel(input logic [3:0] s, input int gap);
    // no wake or irq stimulus between the two writes
    apb(1'b1, A_PRE, {24'h0, scd_pkg::UNLOCK_KEY});
    repeat (gap) @(posedge i_core_clk);
    apb(1'b1, A_PRE, {28'h0, s});
  endtask : key_sel

  // Skips three peripheral pulses, then measures the next gap.
  task io_gap(output int p);
    int n;
    n = 0;
    p = 0;
    while (n < 3 && p < 4000) begin
      @(posedge i_core_clk);
      p++;
      if (o_clk_en.periph_io === 1'b1) n++;
    end
    // A divider that never pulses ends the run as a mismatch.
    if (n < 3) begin
      err_total++;
      print_verdict();
    end
    p = 0;
    do begin
      @(posedge i_core_clk);
      p++;
    end while (o_clk_en.periph_io !== 1'b1 && p < 600);
    if (o_clk_en.periph_io !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask : io_gap

  // Issues a one-cycle sleep instruction and lets the gates settle.
  task sleep_go;
    @(posedge i_core_clk);
    i_sleep_instr <= 1'b1;
    @(posedge i_core_clk);
    i_sleep_instr <= 1'b0;
    repeat (4) @(posedge i_core_clk);
  endtask : sleep_go

  // Waits, bounded, for the wake pulse.
  task wait_wake;
    int n;
    n = 0;
    while (o_wake_irq !== 1'b1 && n < 200) begin
      @(posedge i_core_clk);
      n++;
    end
    if (n >= 200) begin
      err_total++;
      print_verdict();
    end
  endtask : wait_wake

  // Run limit against hangs.
  initial begin
    repeat (100000) @(posedge i_core_clk);
    err_total++;
    print_verdict();
  end

  // Main sequence: table of select codes, then hand-written cases.
  initial begin
    int p, a, c, s;
    logic sh;
    i_sys_rst = 1'b1; i_div8_fuse_prog = 1'b0;
    i_crystal_sel = 1'b1; // crystal source before standby is used
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
    pwdata = 32'h0; i_sleep_instr = 1'b0; i_conv_enabled = 1'b1;
    i_async_used = 1'b1; i_wake = '0;
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    rd_chk(A_PRE, 32'h0);
    foreach (prows[k]) begin
      key_sel(prows[k].sel, 0);
      rd_chk(A_PRE, {28'h0, prows[k].sel});
      io_gap(p);
      chk(p, prows[k].per);
    end
    $display("select table done");
    apb(1'b1, A_PRE, 32'h81);
    apb(1'b1, A_PRE, 32'h05);
    rd_chk(A_PRE, 32'h0);
    apb(1'b1, A_PRE, {24'h0, scd_pkg::UNLOCK_KEY});
    rd_chk(A_PRE, 32'h80);
    @(posedge i_core_clk);
    rd_chk(A_PRE, 32'h0);
    apb(1'b1, A_PRE, 32'h05);
    rd_chk(A_PRE, 32'h0);
    apb(1'b1, A_PRE, {24'h0, scd_pkg::UNLOCK_KEY});
    key_sel(4'h5, 0);
    rd_chk(A_PRE, 32'h0);
    key_sel(4'h9, 0);
    rd_chk(A_PRE, 32'h0);
    apb(1'b0, A_BAD, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("unlock cases done");
    foreach (mrows[k]) begin
      apb(1'b1, A_SLP, {28'h0, mrows[k].code, 1'b1});
      c = n_cs;
      sleep_go();
      a = n_io;
      s = n_cv;
      repeat (8) @(posedge i_core_clk);
      chk({31'h0, o_core_halt}, 32'h1);
      chk({31'h0, n_io != a}, {31'h0, mrows[k].io});
      chk({31'h0, n_cv != s}, {31'h0, mrows[k].cv});
      chk({31'h0, o_main_osc_run}, {31'h0, mrows[k].osc});
      // Async use is on, so only the shallow modes and power-save run.
      sh = mrows[k].code inside {3'h0, 3'h1, 3'h3};
      chk({31'h0, o_async_osc_run}, {31'h0, sh});
      chk({31'h0, o_timer_two_run}, {31'h0, sh});
      if (mrows[k].code == scd_pkg::MODE_IDLE)
        chk(n_cs - c, 32'h1);
      i_wake.pin_change <= 1'b1;
      wait_wake();
      chk({31'h0, o_core_halt}, 32'h0);
      i_wake.pin_change <= 1'b0;
    end
    $display("sleep modes done");
    apb(1'b1, A_SLP, 32'h00);
    sleep_go();
    chk({31'h0, o_core_halt}, 32'h0);
    apb(1'b1, A_SLP, 32'h05);
    sleep_go();
    i_wake.ext_irq0 <= 1'b1;
    repeat (30) @(posedge i_core_clk);
    chk({31'h0, o_core_halt}, 32'h1);
    i_wake.ext_irq0_level <= 1'b1;
    wait_wake();
    i_wake <= '0;
    apb(1'b1, A_SLP, 32'h01);
    sleep_go();
    i_wake.irq_any <= 1'b1;
    wait_wake();
    i_wake <= '0;
    $display("wake cases done");
    apb(1'b1, A_SLP, 32'h05);
    sleep_go();
    i_div8_fuse_prog <= 1'b1;
    i_sys_rst <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    chk({31'h0, o_core_halt}, 32'h0);
    rd_chk(A_PRE, 32'h3);
    io_gap(p);
    chk(p, 32'h8);
    key_sel(4'h0, 0);
    rd_chk(A_PRE, 32'h0);
    $display("reset cases done");
    print_verdict();
  end
endmodule : scd_clock_sleep_tb_top
